// File: core/tec_map.svh
// register offsets, field positions, reset values and timing counts of the timer/event counter
`ifndef TEC_MAP_SVH
`define TEC_MAP_SVH

// ----------------------------------------------------------------------
// register word addresses
// ----------------------------------------------------------------------
`define TEC_ADDR_W          2
`define TEC_ADDR_CSR        2'h0
`define TEC_ADDR_TCR        2'h1

// ----------------------------------------------------------------------
// control/status field positions
// ----------------------------------------------------------------------
`define TEC_BIT_EN          0
`define TEC_BIT_IRQ_EN      1
`define TEC_BIT_INV         2
`define TEC_BIT_MODE_LO     3
`define TEC_BIT_MODE_HI     5
`define TEC_BIT_GPIO        6
`define TEC_BIT_STATUS      7
`define TEC_BIT_DIR         8
`define TEC_BIT_DIN         9
`define TEC_BIT_DOUT        10

// ----------------------------------------------------------------------
// widths, reset values, mode codes
// ----------------------------------------------------------------------
`define TEC_CNT_W           24
`define TEC_CNT_RST         24'h000000
`define TEC_CNT_ALL1        24'hFFFFFF
`define TEC_MODE_TIMER      3'h0
`define TEC_MODE_PULSE      3'h1
`define TEC_MODE_TOGGLE     3'h2
`define TEC_MODE_WIDTH      3'h4
`define TEC_MODE_PERIOD     3'h5
`define TEC_MODE_EXTTIME    3'h6
`define TEC_MODE_EVENT      3'h7

// ----------------------------------------------------------------------
// timing: internal counting clock is the core clock divided by two
// ----------------------------------------------------------------------
`define TEC_CLK_PERIOD_NS   10
`define TEC_DIV             2

`endif

// File: core/tec_pkg.sv
// types shared by the timer/event counter design files
`include "tec_map.svh"

package tec_pkg;

	// ----------------------------------------------------------------------
	// operating modes selected by mode_select
	// ----------------------------------------------------------------------
	typedef enum logic [2:0] {
		TEC_M_TIMER   = `TEC_MODE_TIMER,
		TEC_M_PULSE   = `TEC_MODE_PULSE,
		TEC_M_TOGGLE  = `TEC_MODE_TOGGLE,
		TEC_M_RSVD    = 3'h3,
		TEC_M_WIDTH   = `TEC_MODE_WIDTH,
		TEC_M_PERIOD  = `TEC_MODE_PERIOD,
		TEC_M_EXTTIME = `TEC_MODE_EXTTIME,
		TEC_M_EVENT   = `TEC_MODE_EVENT
	} tec_mode_t;

	// ----------------------------------------------------------------------
	// pulse-width measurement states, one-hot
	// ----------------------------------------------------------------------
	typedef enum logic [1:0] {
		TEC_PW_IDLE = 2'b01,
		TEC_PW_RUN  = 2'b10
	} tec_pw_state_t;

endpackage : tec_pkg

// File: core/tec_edge.sv
// timer pin synchroniser and polarity-aware edge detector
`timescale 1ns/100ps

module tec_edge (
	input  wire logic clk,
	input  wire logic rstn,
	input  wire logic ce,
	input  wire logic hold,
	input  wire logic pin_in,
	input  wire logic pin_polarity_invert,
	output logic      pin_sync,
	output logic      act_rise,
	output logic      act_fall
);

	logic sync1_q;
	logic sync2_q;
	logic act_prev_q;
	logic act_now;

	// ----------------------------------------------------------------------
	// two-stage synchroniser; first stage feeds only the second
	// ----------------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rstn) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
		end else if (ce && !hold) begin
			sync1_q <= pin_in;
			sync2_q <= sync1_q;
		end
	end

	// invert first, so rising always means the selected edge
	assign act_now = sync2_q ^ pin_polarity_invert;

	// previous sample of the active level
	always_ff @(posedge clk) begin
		if (!rstn) begin
			act_prev_q <= 1'b0;
		end else if (ce && !hold) begin
			act_prev_q <= act_now;
		end
	end

	// edges are masked while held so that stop hides pin changes
	assign pin_sync = sync2_q;
	assign act_rise = ce && !hold && act_now && !act_prev_q;
	assign act_fall = ce && !hold && !act_now && act_prev_q;

endmodule : tec_edge

// File: core/tec_top.sv
// timer/event counter: control/status and count value registers, counter and pin logic
`timescale 1ns/100ps
`include "tec_map.svh"

module tec_top #(
	parameter int CNT_W = `TEC_CNT_W
) (
	input  wire logic                   clk,
	input  wire logic                   rstn,
	input  wire logic                   ce,
	input  wire logic                   stop_mode,
	input  wire logic                   irq_ack,
	input  wire logic [`TEC_ADDR_W-1:0] reg_addr,
	input  wire logic [CNT_W-1:0]       reg_wdata,
	input  wire logic                   reg_wr,
	input  wire logic                   reg_rd,
	output logic      [CNT_W-1:0]       reg_rdata,
	input  wire logic                   timer_pin_in,
	output logic                        timer_pin_out,
	output logic                        timer_pin_oe,
	output logic                        count_irq
);

	// ----------------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------------
	logic                   count_enable_q;
	logic                   count_irq_enable_q;
	logic                   pin_polarity_invert_q;
	tec_pkg::tec_mode_t     mode_select_q;
	logic                   gpio_en_q;
	logic                   gpio_dir_q;
	logic                   gpio_dout_q;
	logic                   count_status_flag_q;
	logic [CNT_W-1:0]       count_value_q;
	logic [CNT_W-1:0]       cnt_q;
	logic                   en_prev_q;
	logic                   tick_q;
	logic                   toggle_q;
	tec_pkg::tec_pw_state_t pw_state_q;
	logic [CNT_W-1:0]       rdata_q;
	logic                   pin_out_q;
	logic                   pin_oe_q;
	logic                   irq_q;

	logic                   pin_sync;
	logic                   sel_rise;
	logic                   sel_fall;
	logic                   run;
	logic                   load;
	logic                   step;
	logic                   cnt_zero;
	logic                   hw_event;
	logic                   hw_capture;
	logic [CNT_W-1:0]       cnt_inc;
	logic [CNT_W-1:0]       csr_word;
	logic                   wr_csr;
	logic                   wr_tcr;
	logic                   rd_csr;

	// ----------------------------------------------------------------------
	// pin synchroniser and edge detector
	// ----------------------------------------------------------------------
	tec_edge u_edge (
		.clk      (clk),
		.rstn     (rstn),
		.ce       (ce),
		.hold     (stop_mode),
		.pin_in   (timer_pin_in),
		.pin_polarity_invert      (pin_polarity_invert_q),
		.pin_sync (pin_sync),
		.act_rise (sel_rise),
		.act_fall (sel_fall)
	);

	// ----------------------------------------------------------------------
	// common qualifiers
	// ----------------------------------------------------------------------
	// wait needs no input: only stop or ce low freezes the timer
	assign run      = ce && !stop_mode && count_enable_q;
	assign load     = run && !en_prev_q;
	assign step     = run && !load && tick_q;
	assign cnt_zero = (cnt_q == `TEC_CNT_RST);
	assign cnt_inc  = cnt_q + 1'b1;
	assign wr_csr   = ce && reg_wr && (reg_addr == `TEC_ADDR_CSR);
	assign wr_tcr   = ce && reg_wr && (reg_addr == `TEC_ADDR_TCR);
	assign rd_csr   = ce && reg_rd && (reg_addr == `TEC_ADDR_CSR);

	// status-setting events of the toggle, width, period, external time and event modes
	always_comb begin
		hw_event   = 1'b0;
		hw_capture = 1'b0;
		if (run && !load) begin
			case (mode_select_q)
				tec_pkg::TEC_M_TOGGLE: begin
					hw_event = step && cnt_zero;
				end
				tec_pkg::TEC_M_WIDTH: begin
					hw_event   = sel_fall && (pw_state_q == tec_pkg::TEC_PW_RUN);
					hw_capture = hw_event;
				end
				tec_pkg::TEC_M_PERIOD: begin
					hw_event   = sel_rise;
					hw_capture = sel_rise;
				end
				tec_pkg::TEC_M_EXTTIME: begin
					hw_event   = sel_rise && cnt_zero;
					hw_capture = sel_rise;
				end
				tec_pkg::TEC_M_EVENT: begin
					hw_event = sel_rise && cnt_zero;
				end
				default: begin
					hw_event   = 1'b0;
					hw_capture = 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------------
	// control/status fields written by software
	// ----------------------------------------------------------------------
	// mode and invert should only change while disabled; not enforced here
	always_ff @(posedge clk) begin
		if (!rstn) begin
			count_enable_q        <= 1'b0;
			count_irq_enable_q    <= 1'b0;
			pin_polarity_invert_q <= 1'b0;
			mode_select_q         <= tec_pkg::TEC_M_TIMER;
			gpio_en_q             <= 1'b0;
			gpio_dir_q            <= 1'b0;
			gpio_dout_q           <= 1'b0;
		end else if (wr_csr) begin
			count_enable_q        <= reg_wdata[`TEC_BIT_EN];
			count_irq_enable_q    <= reg_wdata[`TEC_BIT_IRQ_EN];
			pin_polarity_invert_q <= reg_wdata[`TEC_BIT_INV];
			mode_select_q         <= tec_pkg::tec_mode_t'(reg_wdata[`TEC_BIT_MODE_HI:`TEC_BIT_MODE_LO]);
			gpio_en_q             <= reg_wdata[`TEC_BIT_GPIO];
			gpio_dir_q            <= reg_wdata[`TEC_BIT_DIR];
			gpio_dout_q           <= reg_wdata[`TEC_BIT_DOUT];
		end
	end

	// enable history finds the load cycle; frozen while stopped
	always_ff @(posedge clk) begin
		if (!rstn) begin
			en_prev_q <= 1'b0;
		end else if (ce && !stop_mode) begin
			en_prev_q <= count_enable_q;
		end
	end

	// ----------------------------------------------------------------------
	// status flag: a hardware set wins over a read or acknowledge clear
	// ----------------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rstn) begin
			count_status_flag_q <= 1'b0;
		end else if (hw_event) begin
			count_status_flag_q <= 1'b1;
		end else if (rd_csr || (ce && irq_ack)) begin
			count_status_flag_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------------
	// count value register: hardware capture wins over a software write
	// ----------------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rstn) begin
			count_value_q <= `TEC_CNT_RST;
		end else if (hw_capture) begin
			if (mode_select_q == tec_pkg::TEC_M_EXTTIME) begin
				count_value_q <= cnt_inc;
			end else begin
				count_value_q <= cnt_q;
			end
		end else if (wr_tcr) begin
			count_value_q <= reg_wdata;
		end
	end

	// ----------------------------------------------------------------------
	// clock/2 prescaler, restarted by each load
	// ----------------------------------------------------------------------
	// held, not cleared, while ce is low or stopped, so the phase survives
	always_ff @(posedge clk) begin
		if (!rstn) begin
			tick_q <= 1'b0;
		end else if (load || (ce && !stop_mode && !count_enable_q)) begin
			tick_q <= 1'b0;
		end else if (run) begin
			tick_q <= !tick_q;
		end
	end

	// ----------------------------------------------------------------------
	// the counter
	// ----------------------------------------------------------------------
	// a zero reload is only latched at completion, so zero written mid-run
	// lands after the current count
	always_ff @(posedge clk) begin
		if (!rstn) begin
			cnt_q <= `TEC_CNT_RST;
		end else if (load) begin
			case (mode_select_q)
				tec_pkg::TEC_M_EXTTIME: begin
					cnt_q <= ~count_value_q;
				end
				tec_pkg::TEC_M_WIDTH: begin
					cnt_q <= cnt_q;
				end
				default: begin
					// zero on a live counter means a full 2^24 pass first
					if (count_value_q == `TEC_CNT_RST && !cnt_zero) begin
						cnt_q <= `TEC_CNT_ALL1;
					end else begin
						cnt_q <= count_value_q;
					end
				end
			endcase
		end else if (run) begin
			case (mode_select_q)
				tec_pkg::TEC_M_TOGGLE: begin
					if (step) begin
						cnt_q <= cnt_zero ? count_value_q : cnt_q - 1'b1;
					end
				end
				tec_pkg::TEC_M_WIDTH: begin
					if (sel_rise) begin
						cnt_q <= `TEC_CNT_RST;
					end else if (step && pw_state_q == tec_pkg::TEC_PW_RUN) begin
						cnt_q <= cnt_inc;
					end
				end
				tec_pkg::TEC_M_PERIOD: begin
					if (step) begin
						cnt_q <= cnt_inc;
					end
				end
				tec_pkg::TEC_M_EXTTIME: begin
					if (sel_rise) begin
						cnt_q <= cnt_inc;
					end
				end
				tec_pkg::TEC_M_EVENT: begin
					if (sel_rise) begin
						cnt_q <= cnt_zero ? count_value_q : cnt_q - 1'b1;
					end
				end
				default: begin
					cnt_q <= cnt_q;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------------
	// pulse-width measurement sequencer
	// ----------------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rstn) begin
			pw_state_q <= tec_pkg::TEC_PW_IDLE;
		end else if (!ce || stop_mode) begin
			pw_state_q <= pw_state_q;
		end else if (!count_enable_q || load || mode_select_q != tec_pkg::TEC_M_WIDTH) begin
			pw_state_q <= tec_pkg::TEC_PW_IDLE;
		end else begin
			case (pw_state_q)
				tec_pkg::TEC_PW_IDLE: begin
					if (sel_rise) begin
						pw_state_q <= tec_pkg::TEC_PW_RUN;
					end
				end
				tec_pkg::TEC_PW_RUN: begin
					if (sel_fall) begin
						pw_state_q <= tec_pkg::TEC_PW_IDLE;
					end
				end
				default: begin
					pw_state_q <= tec_pkg::TEC_PW_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------------
	// toggle output state
	// ----------------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rstn) begin
			toggle_q <= 1'b0;
		end else if (load) begin
			toggle_q <= 1'b0;
		end else if (hw_event && mode_select_q == tec_pkg::TEC_M_TOGGLE) begin
			toggle_q <= !toggle_q;
		end
	end

	// ----------------------------------------------------------------------
	// pin drive: toggle output, or plain output in the general-purpose mode
	// ----------------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rstn) begin
			pin_out_q <= 1'b0;
			pin_oe_q  <= 1'b0;
		end else if (ce) begin
			if (mode_select_q == tec_pkg::TEC_M_TOGGLE) begin
				pin_out_q <= toggle_q ^ pin_polarity_invert_q;
				pin_oe_q  <= 1'b1;
			end else if (mode_select_q == tec_pkg::TEC_M_TIMER && gpio_en_q && gpio_dir_q) begin
				pin_out_q <= gpio_dout_q ^ pin_polarity_invert_q;
				pin_oe_q  <= 1'b1;
			end else begin
				pin_out_q <= 1'b0;
				pin_oe_q  <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------------
	// interrupt request: pending status gated by its enable
	// ----------------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rstn) begin
			irq_q <= 1'b0;
		end else if (ce) begin
			irq_q <= count_status_flag_q && count_irq_enable_q;
		end
	end

	// ----------------------------------------------------------------------
	// register read port, data one cycle after the strobe
	// ----------------------------------------------------------------------
	always_comb begin
		csr_word                                    = '0;
		csr_word[`TEC_BIT_EN]                       = count_enable_q;
		csr_word[`TEC_BIT_IRQ_EN]                   = count_irq_enable_q;
		csr_word[`TEC_BIT_INV]                      = pin_polarity_invert_q;
		csr_word[`TEC_BIT_MODE_HI:`TEC_BIT_MODE_LO] = mode_select_q;
		csr_word[`TEC_BIT_GPIO]                     = gpio_en_q;
		csr_word[`TEC_BIT_STATUS]                   = count_status_flag_q;
		csr_word[`TEC_BIT_DIR]                      = gpio_dir_q;
		csr_word[`TEC_BIT_DIN]                      = pin_sync ^ pin_polarity_invert_q;
		csr_word[`TEC_BIT_DOUT]                     = gpio_dout_q;
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			rdata_q <= '0;
		end else if (ce) begin
			if (reg_rd && reg_addr == `TEC_ADDR_CSR) begin
				rdata_q <= csr_word;
			end else if (reg_rd && reg_addr == `TEC_ADDR_TCR) begin
				rdata_q <= count_value_q;
			end else begin
				rdata_q <= '0;                                            // unmapped or idle
			end
		end
	end

	assign reg_rdata     = rdata_q;
	assign timer_pin_out = pin_out_q;
	assign timer_pin_oe  = pin_oe_q;
	assign count_irq     = irq_q;

	// ----------------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	sequence s_toggle_end;
		run && !load && mode_select_q == tec_pkg::TEC_M_TOGGLE && step && cnt_zero;
	endsequence

	sequence s_width_start;
		run && !load && mode_select_q == tec_pkg::TEC_M_WIDTH && sel_rise;
	endsequence

	sequence s_width_end;
		run && !load && mode_select_q == tec_pkg::TEC_M_WIDTH && hw_event;
	endsequence

	chk_toggle_reload: assert property (s_toggle_end |=> cnt_q == $past(count_value_q)
		&& count_status_flag_q) else $error("toggle mode did not reload and flag");
	chk_toggle_pin: assert property (s_toggle_end |=> toggle_q != $past(toggle_q))
		else $error("toggle output did not invert");
	chk_toggle_decr: assert property (run && !load && mode_select_q == tec_pkg::TEC_M_TOGGLE
		&& step && !cnt_zero |=> cnt_q == $past(cnt_q) - 1'b1 ##1 $stable(cnt_q) || !ce)
		else $error("toggle counter step wrong");
	chk_width_clear: assert property (s_width_start |=> cnt_q == '0
		&& pw_state_q == tec_pkg::TEC_PW_RUN) else $error("width start not cleared");
	chk_width_capture: assert property (s_width_end |=> count_value_q == $past(cnt_q)
		&& count_status_flag_q && pw_state_q == tec_pkg::TEC_PW_IDLE)
		else $error("width capture wrong");
	chk_period_capture: assert property (run && !load && mode_select_q == tec_pkg::TEC_M_PERIOD
		&& sel_rise |=> count_value_q == $past(cnt_q) && count_status_flag_q)
		else $error("period capture wrong");
	chk_ext_increment: assert property (run && !load && mode_select_q == tec_pkg::TEC_M_EXTTIME
		&& sel_rise |=> cnt_q == $past(cnt_q) + 1'b1 && count_value_q == cnt_q)
		else $error("external time step wrong");
	chk_event_reload: assert property (run && !load && mode_select_q == tec_pkg::TEC_M_EVENT
		&& sel_rise && cnt_zero |=> cnt_q == $past(count_value_q) && count_status_flag_q)
		else $error("event reload wrong");
	chk_stop_freeze: assert property (stop_mode |=> $stable(cnt_q))
		else $error("counter moved in stop");
	chk_status_clear: assert property (rd_csr && !hw_event |=> !count_status_flag_q)
		else $error("status not cleared by read");
	chk_irq_gate: assert property (ce && count_status_flag_q && count_irq_enable_q
		|=> count_irq) else $error("interrupt not raised");

endmodule : tec_top

// File: test/tec_pin_src.sv
// pin source model: square wave on the timer pin while running
`timescale 1ns/100ps

module tec_pin_src (
	input  wire logic       clk,
	input  wire logic       run,
	input  wire logic [7:0] half,
	output logic            pin
);
	logic [7:0] cnt_q = 8'h00;
	logic       pin_q = 1'b0;

	// ----------------------------------------------------------------------
	// wave generator
	// ----------------------------------------------------------------------
	// level held between bursts, as a real source would do
	assign pin = pin_q;
	// half of four or more keeps the source below clk/4
	always @(posedge clk) begin
		if (!run) begin
			cnt_q <= 8'h00;
		end else if (cnt_q == half - 8'h01) begin
			cnt_q <= 8'h00;
			pin_q <= ~pin_q;
		end else begin
			cnt_q <= cnt_q + 8'h01;
		end
	end
endmodule : tec_pin_src

// File: test/tec_top_tb_top.sv
// self-checking bench of the timer/event counter
`timescale 1ns/100ps
`include "tec_map.svh"

module tec_top_tb_top;
	localparam logic [1:0] A_CSR = `TEC_ADDR_CSR;
	localparam logic [1:0] A_TCR = `TEC_ADDR_TCR;
	logic        clk = 1'b0, rstn = 1'b0, stop_mode = 1'b0, irq_ack = 1'b0, ce = 1'b1;
	logic        reg_wr = 1'b0, reg_rd = 1'b0, run = 1'b0, pin, pv;
	logic [1:0]  reg_addr = 2'h0;
	logic [23:0] reg_wdata = 24'h000000, reg_rdata, rd_v, a_v;
	logic        timer_pin_out, timer_pin_oe, count_irq;
	logic [7:0]  half = 8'h04;
	int          mismatches = 0, n_checks = 0, seed = 32'h04F72244, n, c, e;

	// ----------------------------------------------------------------------
	// clock, partner and design
	// ----------------------------------------------------------------------
	always #5 clk = ~clk;
	tec_pin_src src (.clk(clk), .run(run), .half(half), .pin(pin));
	tec_top dut (.clk(clk), .rstn(rstn), .ce(ce), .stop_mode(stop_mode),
		.irq_ack(irq_ack), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer_pin_in(pin),
		.timer_pin_out(timer_pin_out), .timer_pin_oe(timer_pin_oe), .count_irq(count_irq));

	// ----------------------------------------------------------------------
	// expectations, bus cycles and waits
	// ----------------------------------------------------------------------
	function automatic logic [23:0] ext_exp(input logic [23:0] v, input int m);
		return ~v + 24'(m);
	endfunction : ext_exp
	task chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task wr(input logic [1:0] a, input logic [23:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	// data stand only in the cycle after the strobe, so sample mid-cycle
	task rd(input logic [1:0] a, output logic [23:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		d = reg_rdata;
	endtask : rd
	task wait_irq();
		c = 0;
		while (count_irq !== 1'b1 && c < 3000) begin
			@(negedge clk);
			c++;
		end
		chk("irq_seen", 24'h1, {23'h0, count_irq});
	endtask : wait_irq
	// counts selected pin edges; stop_irq ends the wait at the interrupt
	task edges(input int want, input logic fall, input logic stop_irq);
		e = 0;
		c = 0;
		pv = pin;
		while (e < want && c < 3000 && !(stop_irq && count_irq === 1'b1)) begin
			@(negedge clk);
			c++;
			if (pin !== pv && pin === ~fall) e++;
			pv = pin;
		end
	endtask : edges
	task flip_gap();
		pv = timer_pin_out;
		c = 0;
		do begin
			@(negedge clk);
			c++;
		end while (timer_pin_out === pv && c < 3000);
	endtask : flip_gap
	task final_report();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : final_report

	// ----------------------------------------------------------------------
	// watchdog and test sequence
	// ----------------------------------------------------------------------
	// generous bound: the whole sequence needs only a few hundred cycles
	initial begin
		repeat (30000) @(posedge clk);
		mismatches++;
		final_report();
	end
	initial begin
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		rd(A_CSR, rd_v); chk("csr_reset", 24'h000000, rd_v);
		rd(A_TCR, rd_v); chk("tcr_reset", 24'h000000, rd_v);
		rd(2'h3, rd_v); chk("unmapped", 24'h000000, rd_v);
		$display("test reset done");
		// toggle mode: small random reload, pin flips every 2(n+1) clocks
		n = ($random(seed) & 7) + 1;
		wr(A_TCR, 24'(n));
		wr(A_CSR, 24'h000013);
		wait_irq();
		rd(A_CSR, rd_v); chk("csr_status", 24'h000093, rd_v);
		chk("pin_oe", 24'h1, {23'h0, timer_pin_oe});
		flip_gap();
		flip_gap(); chk("toggle_gap", 24'(2 * (n + 1)), 24'(c));
		wr(A_CSR, 24'h000000);
		$display("test toggle done");
		// period mode: capture difference equals the full pin period in clk/2 steps, i.e. half
		half <= 8'(($random(seed) & 7) + 8);
		run  <= 1'b1;
		rd(A_CSR, rd_v);
		wr(A_CSR, 24'h00002B);
		wait_irq();
		rd(A_CSR, rd_v);
		rd(A_TCR, a_v);
		wait_irq();
		rd(A_TCR, rd_v); chk("period_delta", {16'h0, half}, rd_v - a_v);
		run <= 1'b0;
		wr(A_CSR, 24'h000000);
		$display("test period done");
		// event mode, inverted: interrupt at the n+1-th falling edge
		n = ($random(seed) & 7) + 1;
		wr(A_TCR, 24'(n));
		rd(A_CSR, rd_v);
		half <= 8'h06;
		wr(A_CSR, 24'h00003F);
		run <= 1'b1;
		edges(100, 1'b1, 1'b1); chk("event_count", 24'(n + 1), 24'(e));
		run <= 1'b0;
		@(posedge clk);
		irq_ack <= 1'b1;
		@(posedge clk);
		irq_ack <= 1'b0;
		repeat (3) @(negedge clk);
		chk("irq_ack", 24'h0, {23'h0, count_irq});
		wr(A_CSR, 24'h000000);
		$display("test event done");
		// external time mode, then stop state ignores pin edges
		a_v = 24'($random(seed));
		n = ($random(seed) & 7) + 1;
		wr(A_TCR, a_v);
		wr(A_CSR, 24'h000031);
		half <= 8'h05;
		run  <= 1'b1;
		edges(n, 1'b0, 1'b0);
		run <= 1'b0;
		repeat (6) @(posedge clk);
		rd(A_TCR, rd_v); chk("ext_count", ext_exp(a_v, n), rd_v);
		@(posedge clk);
		stop_mode <= 1'b1;
		run       <= 1'b1;
		edges(4, 1'b0, 1'b0);
		run <= 1'b0;
		@(posedge clk);
		stop_mode <= 1'b0;
		repeat (6) @(posedge clk);
		rd(A_TCR, rd_v); chk("stop_hold", ext_exp(a_v, n), rd_v);
		// clock enable low freezes the counter like stop does
		@(posedge clk);
		ce  <= 1'b0;
		run <= 1'b1;
		edges(4, 1'b0, 1'b0);
		run <= 1'b0;
		@(posedge clk);
		ce <= 1'b1;
		repeat (6) @(posedge clk);
		rd(A_TCR, rd_v); chk("ce_hold", ext_exp(a_v, n), rd_v);
		$display("test ext_stop done");
		// width mode: odd high pulse gives (half-1)/2 clock/2 steps
		half <= 8'(2 * ($random(seed) & 3) + 9);
		rd(A_CSR, rd_v);
		wr(A_CSR, 24'h000023);
		run <= 1'b1;
		wait_irq();
		rd(A_TCR, rd_v); chk("width_count", 24'((half - 8'h01) >> 1), rd_v);
		run <= 1'b0;
		$display("test width done");
		final_report();
	end
endmodule : tec_top_tb_top
